// File: verilog/panel_pkg.sv
// constants shared by the front-panel control routing design
package panel_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h10;
  // control register fields
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_LATE_BIT   = 2;
  localparam int CTRL_WORD24_BIT = 3;
  localparam logic [1:0] CTRL_MODE_RESET = 2'h0;
  localparam logic CTRL_LATE_RESET   = 1'b0;
  localparam logic CTRL_WORD24_RESET = 1'b0;
  // input mode encodings
  localparam logic [1:0] MODE_USER2    = 2'h0;
  localparam logic [1:0] MODE_INHIBIT3 = 2'h1;
  localparam logic [1:0] MODE_INHIBIT4 = 2'h2;
  localparam logic [1:0] MODE_TEST     = 2'h3;
  // status register fields
  localparam int STAT_FLAG_LSB = 0;
  localparam int STAT_IN_LSB   = 2;
  localparam int STAT_OUT_LSB  = 6;
  // interrupt sources
  localparam int IRQ_WIDTH     = 4;
  localparam int IRQ_NEXT      = 0;
  localparam int IRQ_DROPPED   = 1;
  localparam int IRQ_EXT_RESET = 2;
  localparam int IRQ_FIFO_FULL = 3;
  localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 4'h0;
  // data word layout in 24-bit mode
  localparam int WORD_COUNT_W  = 24;
  localparam int WORD_CHAN_LSB = 24;
  localparam int WORD_BANK_BIT = 29;
  localparam int WORD_LOW_BIT  = 30;
  localparam int WORD_HIGH_BIT = 31;
  // highest counter input rates in MHz, clock rate in MHz
  localparam int RATE_FAST_MHZ = 200;
  localparam int RATE_TTL_MHZ  = 100;
  localparam int CLOCK_MHZ     = 125;
endpackage : panel_pkg

// File: verilog/rise_detect.sv
// one-cycle pulse on the rising edge of a synchronous level
`timescale 1ns/100ps
module rise_detect (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_level,
  output logic      o_rise
);
  typedef struct packed {
    logic prev;
    logic rise;
  } rise_state_t;

  rise_state_t st_ff;
  rise_state_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = i_level;
    nxt_st.rise = i_level & ~st_ff.prev;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rise = st_ff.rise;
endmodule : rise_detect

// File: verilog/irq_block.sv
// sticky interrupt status, enable and write-one-to-clear
`timescale 1ns/100ps
module irq_block (
  input  wire logic                            i_clock,
  input  wire logic                            i_rst,
  input  wire logic [panel_pkg::IRQ_WIDTH-1:0] i_event,
  input  wire logic                            i_enable_wr,
  input  wire logic                            i_clear_wr,
  input  wire logic [panel_pkg::IRQ_WIDTH-1:0] i_wdata,
  output logic      [panel_pkg::IRQ_WIDTH-1:0] o_status,
  output logic      [panel_pkg::IRQ_WIDTH-1:0] o_enable,
  output logic                                 o_irq
);
  typedef struct packed {
    logic [panel_pkg::IRQ_WIDTH-1:0] status;
    logic [panel_pkg::IRQ_WIDTH-1:0] enable;
  } irq_state_t;

  irq_state_t st_ff;
  irq_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // a new event wins over a clear in the same cycle
    if (i_clear_wr) begin
      nxt_st.status = st_ff.status & ~i_wdata;
    end
    nxt_st.status = nxt_st.status | i_event;
    if (i_enable_wr) begin
      nxt_st.enable = i_wdata;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= {panel_pkg::IRQ_RESET, panel_pkg::IRQ_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_status = st_ff.status;
  assign o_enable = st_ff.enable;
  assign o_irq    = |(st_ff.status & st_ff.enable);
endmodule : irq_block

// File: verilog/panel_routing.sv
// front-panel control line routing for the multiscaler
//
// Contract
// - mode 0: in1 next pulse, in2/in3 user flags, in4 reset (early).
// - mode 1: in1 next pulse, in2 user flag, in3 counting inhibit.
// - later variants, modes 0 and 1: in4 blocks next pulses instead.
// - mode 2: in1 next, in2/in3 user flags, in4 disables counting.
// - mode 3: in4 is an external test pulse into the counters.
// - control lines 5 to 8 are always outputs.
// - line 5 carries copy in progress, line 6 fifo empty.
// - line 7 carries fifo half full, line 8 fifo full.
// - counting stops for as long as the inhibit input is held.
// - 24-bit mode latches user flags on next pulse leading edge.
// - counters take up to 200 MHz fast inputs, 100 MHz ttl.
// - latched user flags sit in the data word upper byte.
`timescale 1ns/100ps
module panel_routing (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_irq,
  // control lines 1 to 4
  input  wire logic [3:0]  i_ctrl_in,
  // board state shown on lines 5 to 8
  input  wire logic        i_copy_in_progress,
  input  wire logic        i_fifo_empty,
  input  wire logic        i_fifo_half_full,
  input  wire logic        i_fifo_full,
  output logic      [3:0]  o_ctrl_out,
  // to the counter logic
  output logic             o_next_time_slice_pulse,
  output logic             o_counter_reset,
  output logic             o_test_pulse,
  output logic             o_count_enable,
  output logic             o_user_flag_high,
  output logic             o_user_flag_low,
  // data word assembly
  input  wire logic        i_word_valid,
  input  wire logic [23:0] i_word_count,
  input  wire logic        i_word_bank,
  input  wire logic [4:0]  i_word_channel,
  output logic      [31:0] o_data_word,
  output logic             o_data_valid
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  mode;
    logic        late;
    logic        word24;
    logic        flag_high;
    logic        flag_low;
    logic        next_pulse;
    logic        counter_reset;
    logic        test_pulse;
    logic        count_enable;
    logic [3:0]  line_out;
    logic        full_prev;
    logic [31:0] data_word;
    logic        data_valid;
    logic [31:0] rdata;
  } route_state_t;

  route_state_t st_ff;
  route_state_t nxt_st;

  logic                            rise_next;
  logic                            rise_fourth;
  logic [panel_pkg::IRQ_WIDTH-1:0] irq_event;
  logic [panel_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [panel_pkg::IRQ_WIDTH-1:0] irq_enable;
  logic                            wr_enable;
  logic                            wr_clear;
  logic                            in4_blocks;
  logic                            in4_resets;
  logic                            inhibit;
  logic                            next_ok;

  // address match used by every register access
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // ------------------------------------------------------------------
  // edge detectors
  // ------------------------------------------------------------------
  rise_detect u_rise_next (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_level (i_ctrl_in[0]),
    .o_rise  (rise_next)
  );

  rise_detect u_rise_fourth (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_level (i_ctrl_in[3]),
    .o_rise  (rise_fourth)
  );

  // ------------------------------------------------------------------
  // input role decode
  // ------------------------------------------------------------------
  always_comb begin
    // in4 blocks next pulses only in later variants, modes 0 and 1
    in4_blocks = st_ff.late & ~st_ff.mode[1] & i_ctrl_in[3];
    in4_resets = ~st_ff.late & ~st_ff.mode[1] & rise_fourth;
    case (st_ff.mode)
      panel_pkg::MODE_INHIBIT3: inhibit = i_ctrl_in[2];
      panel_pkg::MODE_INHIBIT4: inhibit = i_ctrl_in[3];
      default:                  inhibit = 1'b0;
    endcase
    // mode 3 gives in1 no role
    next_ok = rise_next & (st_ff.mode != panel_pkg::MODE_TEST);
  end

  assign wr_enable = i_wr & hit(i_addr, panel_pkg::ADDR_IRQ_ENABLE);
  assign wr_clear  = i_wr & hit(i_addr, panel_pkg::ADDR_IRQ_CLEAR);

  always_comb begin
    irq_event = '0;
    irq_event[panel_pkg::IRQ_NEXT]      = next_ok & ~in4_blocks;
    irq_event[panel_pkg::IRQ_DROPPED]   = next_ok & in4_blocks;
    irq_event[panel_pkg::IRQ_EXT_RESET] = in4_resets;
    irq_event[panel_pkg::IRQ_FIFO_FULL] = i_fifo_full & ~st_ff.full_prev;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.next_pulse    = next_ok & ~in4_blocks;
    nxt_st.counter_reset = in4_resets;
    nxt_st.test_pulse    = (st_ff.mode == panel_pkg::MODE_TEST)
                           & rise_fourth;
    // enable goes to counters rated at the fast and ttl maxima
    nxt_st.count_enable  = ~inhibit;
    nxt_st.line_out      = {i_fifo_full, i_fifo_half_full,
                            i_fifo_empty, i_copy_in_progress};
    nxt_st.full_prev     = i_fifo_full;
    // user flags latched on the leading edge of the next pulse
    if (next_ok && st_ff.word24) begin
      nxt_st.flag_low = i_ctrl_in[1];
      if (st_ff.mode != panel_pkg::MODE_INHIBIT3) begin
        nxt_st.flag_high = i_ctrl_in[2];
      end
    end
    // data word with flags, bank and channel in the upper byte
    nxt_st.data_valid = i_word_valid;
    if (i_word_valid) begin
      nxt_st.data_word = {st_ff.flag_high, st_ff.flag_low,
                          i_word_bank, i_word_channel, i_word_count};
    end
    // register writes
    if (i_wr && hit(i_addr, panel_pkg::ADDR_CONTROL)) begin
      nxt_st.mode   = i_wdata[panel_pkg::CTRL_MODE_LSB +: 2];
      nxt_st.late   = i_wdata[panel_pkg::CTRL_LATE_BIT];
      nxt_st.word24 = i_wdata[panel_pkg::CTRL_WORD24_BIT];
    end
    // register reads, data in the following cycle only
    nxt_st.rdata = '0;
    if (i_rd) begin
      if (hit(i_addr, panel_pkg::ADDR_CONTROL)) begin
        nxt_st.rdata[panel_pkg::CTRL_MODE_LSB +: 2]  = st_ff.mode;
        nxt_st.rdata[panel_pkg::CTRL_LATE_BIT]       = st_ff.late;
        nxt_st.rdata[panel_pkg::CTRL_WORD24_BIT]     = st_ff.word24;
      end else if (hit(i_addr, panel_pkg::ADDR_STATUS)) begin
        nxt_st.rdata[panel_pkg::STAT_FLAG_LSB +: 2]  = {st_ff.flag_high,
                                                        st_ff.flag_low};
        nxt_st.rdata[panel_pkg::STAT_IN_LSB +: 4]    = i_ctrl_in;
        nxt_st.rdata[panel_pkg::STAT_OUT_LSB +: 4]   = st_ff.line_out;
      end else if (hit(i_addr, panel_pkg::ADDR_IRQ_STATUS)) begin
        nxt_st.rdata[panel_pkg::IRQ_WIDTH-1:0]       = irq_status;
      end else if (hit(i_addr, panel_pkg::ADDR_IRQ_ENABLE)) begin
        nxt_st.rdata[panel_pkg::IRQ_WIDTH-1:0]       = irq_enable;
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_ff              <= '0;
      st_ff.mode         <= panel_pkg::CTRL_MODE_RESET;
      st_ff.late         <= panel_pkg::CTRL_LATE_RESET;
      st_ff.word24       <= panel_pkg::CTRL_WORD24_RESET;
      st_ff.count_enable <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------------
  irq_block u_irq (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_event     (irq_event),
    .i_enable_wr (wr_enable),
    .i_clear_wr  (wr_clear),
    .i_wdata     (i_wdata[panel_pkg::IRQ_WIDTH-1:0]),
    .o_status    (irq_status),
    .o_enable    (irq_enable),
    .o_irq       (o_irq)
  );

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign o_rdata                 = st_ff.rdata;
  assign o_ctrl_out              = st_ff.line_out;
  assign o_next_time_slice_pulse = st_ff.next_pulse;
  assign o_counter_reset         = st_ff.counter_reset;
  assign o_test_pulse            = st_ff.test_pulse;
  assign o_count_enable          = st_ff.count_enable;
  assign o_user_flag_high        = st_ff.flag_high;
  assign o_user_flag_low         = st_ff.flag_low;
  assign o_data_word             = st_ff.data_word;
  assign o_data_valid            = st_ff.data_valid;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_next_mode;
    @(posedge i_clock) disable iff (i_rst)
    o_next_time_slice_pulse |-> $past(st_ff.mode) != 2'h3;
  endproperty
  a_next_mode: assert property (p_next_mode)
    else $error("next pulse issued in test mode");

  property p_reset_early;
    @(posedge i_clock) disable iff (i_rst)
    o_counter_reset |-> !$past(st_ff.late) && !$past(st_ff.mode[1]);
  endproperty
  a_reset_early: assert property (p_reset_early)
    else $error("reset pulse outside early modes 0 and 1");

  property p_late_block;
    @(posedge i_clock) disable iff (i_rst)
    st_ff.late && !st_ff.mode[1] && i_ctrl_in[3] && rise_next
      |=> !o_next_time_slice_pulse;
  endproperty
  a_late_block: assert property (p_late_block)
    else $error("next pulse passed while in4 blocks it");

  property p_inhibit3;
    @(posedge i_clock) disable iff (i_rst)
    st_ff.mode == 2'h1 && i_ctrl_in[2] |=> !o_count_enable;
  endproperty
  a_inhibit3: assert property (p_inhibit3)
    else $error("counting not stopped by in3 in mode 1");

  property p_inhibit4;
    @(posedge i_clock) disable iff (i_rst)
    st_ff.mode == 2'h2 && i_ctrl_in[3] |=> !o_count_enable;
  endproperty
  a_inhibit4: assert property (p_inhibit4)
    else $error("counting not stopped by in4 in mode 2");

  property p_enable_cause;
    @(posedge i_clock) disable iff (i_rst)
    !o_count_enable |-> $past(st_ff.mode) inside {2'h1, 2'h2};
  endproperty
  a_enable_cause: assert property (p_enable_cause)
    else $error("counting stopped in a mode without inhibit");

  property p_lines;
    @(posedge i_clock) disable iff (i_rst)
    ##1 o_ctrl_out == $past({i_fifo_full, i_fifo_half_full,
                             i_fifo_empty, i_copy_in_progress});
  endproperty
  a_lines: assert property (p_lines)
    else $error("lines 5 to 8 do not follow board state");

  property p_flag_latch;
    @(posedge i_clock) disable iff (i_rst)
    $changed(o_user_flag_low) || $changed(o_user_flag_high)
      |-> $past(rise_next) && $past(st_ff.word24)
          && $past(st_ff.mode) != 2'h3;
  endproperty
  a_flag_latch: assert property (p_flag_latch)
    else $error("user flag changed without next pulse edge");

  property p_word;
    @(posedge i_clock) disable iff (i_rst)
    i_word_valid |=> o_data_valid
      && o_data_word[31:24] == {$past(st_ff.flag_high),
         $past(st_ff.flag_low), $past(i_word_bank),
         $past(i_word_channel)};
  endproperty
  a_word: assert property (p_word)
    else $error("data word upper byte wrong");

  property p_test_pulse;
    @(posedge i_clock) disable iff (i_rst)
    o_test_pulse |-> $past(st_ff.mode) == 2'h3;
  endproperty
  a_test_pulse: assert property (p_test_pulse)
    else $error("test pulse issued outside test mode");

  property p_early_reset;
    @(posedge i_clock) disable iff (i_rst)
    !st_ff.late && !st_ff.mode[1] && rise_fourth |=> o_counter_reset;
  endproperty
  a_early_reset: assert property (p_early_reset)
    else $error("in4 edge gave no reset pulse in early modes 0 and 1");

  property p_flag_hold;
    @(posedge i_clock) disable iff (i_rst)
    st_ff.mode == 2'h1 && rise_next |=> $stable(o_user_flag_high);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("in3 latched as a user flag in mode 1");

  property p_count_free;
    @(posedge i_clock) disable iff (i_rst)
    st_ff.mode == 2'h0 || st_ff.mode == 2'h3 |=> o_count_enable;
  endproperty
  a_count_free: assert property (p_count_free)
    else $error("counting stopped in a mode without inhibit input");

  property p_cip_line;
    @(posedge i_clock) disable iff (i_rst)
    i_copy_in_progress |=> o_ctrl_out[0];
  endproperty
  a_cip_line: assert property (p_cip_line)
    else $error("line 5 does not show copy in progress");

  cover property (@(posedge i_clock) disable iff (i_rst)
    o_next_time_slice_pulse ##[1:20] o_data_valid);
  cover property (@(posedge i_clock) disable iff (i_rst)
    o_test_pulse);
  cover property (@(posedge i_clock) disable iff (i_rst)
    !o_count_enable ##1 o_count_enable);
  cover property (@(posedge i_clock) disable iff (i_rst)
    o_irq);
endmodule : panel_routing

// File: verif/panel_far_side.sv
// model of the experiment electronics driving control lines 1 to 4
`timescale 1ns/100ps
module panel_far_side (
  input  wire logic i_clock,
  output logic [3:0] o_ctrl_in
);
  // --------------------------------------------------------------------
  // line drivers
  // --------------------------------------------------------------------
  initial o_ctrl_in = 4'h0;

  // holds a line at a level until told otherwise
  task automatic level(input int line, input logic v);
    @(posedge i_clock);
    o_ctrl_in[line] <= v;
  endtask : level

  // high for width cycles, then low long enough for a fresh edge
  task automatic pulse(input int line, input int width);
    level(line, 1'b1);
    repeat (width - 1) @(posedge i_clock);
    level(line, 1'b0);
    repeat (4) @(posedge i_clock);
  endtask : pulse
endmodule : panel_far_side

// File: verif/test_panel_routing.sv
// self-checking bench for the front-panel control routing
`timescale 1ns/100ps
module test_panel_routing;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic        o_irq;
  logic [3:0]  i_ctrl_in;
  logic        i_copy_in_progress = 1'b0;
  logic        i_fifo_empty = 1'b0;
  logic        i_fifo_half_full = 1'b0;
  logic        i_fifo_full = 1'b0;
  logic [3:0]  o_ctrl_out;
  logic        o_next_time_slice_pulse;
  logic        o_counter_reset;
  logic        o_test_pulse;
  logic        o_count_enable;
  logic        o_user_flag_high;
  logic        o_user_flag_low;
  logic        i_word_valid = 1'b0;
  logic [23:0] i_word_count = 24'h0;
  logic        i_word_bank = 1'b0;
  logic [4:0]  i_word_channel = 5'h0;
  logic [31:0] o_data_word;
  logic        o_data_valid;
  logic [31:0] rv;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          n_next = 0;
  int          n_rst = 0;
  int          n_test = 0;

  // --------------------------------------------------------------------
  // clock, design and far side
  // --------------------------------------------------------------------
  always #4 i_clock = ~i_clock;

  panel_routing dut (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_irq, .i_ctrl_in, .i_copy_in_progress, .i_fifo_empty,
    .i_fifo_half_full, .i_fifo_full, .o_ctrl_out, .o_next_time_slice_pulse,
    .o_counter_reset, .o_test_pulse, .o_count_enable, .o_user_flag_high,
    .o_user_flag_low, .i_word_valid, .i_word_count, .i_word_bank,
    .i_word_channel, .o_data_word, .o_data_valid);

  panel_far_side far (.i_clock(i_clock), .o_ctrl_in(i_ctrl_in));

  // counts the pulses sent to the counter logic
  always @(posedge i_clock) begin
    if (o_next_time_slice_pulse === 1'b1) n_next++;
    if (o_counter_reset === 1'b1) n_rst++;
    if (o_test_pulse === 1'b1) n_test++;
  end

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(what, exp, o_rdata);
  endtask : rdchk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : cyc

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (5000) @(posedge i_clock);
    $display("[ERR] watchdog expected done seen hang");
    fail_count++;
    complete_run();
  end

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    cyc(1);
    rdchk("control", panel_pkg::ADDR_CONTROL, 32'h0);
    rdchk("irq enable", panel_pkg::ADDR_IRQ_ENABLE, 32'h0);
    chk("count enable", 32'h1, {31'h0, o_count_enable});
    wr(panel_pkg::ADDR_CONTROL, 32'hffff_ffff);
    rdchk("control", panel_pkg::ADDR_CONTROL, 32'h0000_000f);
    wr(8'h20, 32'hffff_ffff);
    rdchk("unmapped", 8'h20, 32'h0);
    rdchk("irq clear", panel_pkg::ADDR_IRQ_CLEAR, 32'h0);
    wr(panel_pkg::ADDR_CONTROL, 32'h0);
    $display("test registers done");

    for (int v = 0; v < 16; v++) begin
      @(posedge i_clock);
      {i_fifo_full, i_fifo_half_full, i_fifo_empty, i_copy_in_progress}
        <= v[3:0];
      cyc(2);
      chk("lines 5-8", {28'h0, v[3:0]}, {28'h0, o_ctrl_out});
    end
    rdchk("status", panel_pkg::ADDR_STATUS, 32'h3c0);
    rdchk("irq status", panel_pkg::ADDR_IRQ_STATUS, 32'h8);
    wr(panel_pkg::ADDR_IRQ_STATUS, 32'h0);
    rdchk("irq status", panel_pkg::ADDR_IRQ_STATUS, 32'h8);
    wr(panel_pkg::ADDR_IRQ_CLEAR, 32'hf);
    rdchk("irq status", panel_pkg::ADDR_IRQ_STATUS, 32'h0);
    $display("test outputs done");

    wr(panel_pkg::ADDR_CONTROL, 32'h8);
    far.level(2, 1'b1);
    far.pulse(0, 1);
    chk("next count", 32'd1, n_next);
    rdchk("status", panel_pkg::ADDR_STATUS, 32'h3d2);
    far.pulse(3, 1);
    chk("reset count", 32'd1, n_rst);
    rdchk("irq status", panel_pkg::ADDR_IRQ_STATUS, 32'h5);
    $display("test mode 0 done");

    wr(panel_pkg::ADDR_CONTROL, 32'h9);
    cyc(3);
    chk("count enable", 32'h0, {31'h0, o_count_enable});
    far.level(2, 1'b0);
    cyc(3);
    chk("count enable", 32'h1, {31'h0, o_count_enable});
    far.level(1, 1'b1);
    far.pulse(0, 1);
    rdchk("status", panel_pkg::ADDR_STATUS, 32'h3cb);
    $display("test mode 1 done");

    wr(panel_pkg::ADDR_CONTROL, 32'hc);
    far.level(3, 1'b1);
    far.pulse(0, 3);
    chk("reset count", 32'd1, n_rst);
    chk("next count", 32'd2, n_next);
    rdchk("irq status", panel_pkg::ADDR_IRQ_STATUS, 32'h7);
    far.level(3, 1'b0);
    far.pulse(0, 1);
    chk("next count", 32'd3, n_next);
    $display("test later variant done");

    wr(panel_pkg::ADDR_CONTROL, 32'h2);
    far.level(1, 1'b0);
    far.pulse(0, 1);
    chk("next count", 32'd4, n_next);
    far.level(3, 1'b1);
    cyc(3);
    chk("count enable", 32'h0, {31'h0, o_count_enable});
    far.level(3, 1'b0);
    cyc(3);
    chk("count enable", 32'h1, {31'h0, o_count_enable});
    chk("reset count", 32'd1, n_rst);
    rdchk("status", panel_pkg::ADDR_STATUS, 32'h3c1);
    $display("test mode 2 done");

    wr(panel_pkg::ADDR_CONTROL, 32'h3);
    far.pulse(0, 1);
    far.level(2, 1'b1);
    cyc(3);
    chk("next count", 32'd4, n_next);
    chk("count enable", 32'h1, {31'h0, o_count_enable});
    far.level(2, 1'b0);
    far.pulse(3, 2);
    chk("test count", 32'd1, n_test);
    chk("reset count", 32'd1, n_rst);
    $display("test mode 3 done");

    @(posedge i_clock);
    i_word_valid <= 1'b1;
    i_word_count <= 24'habcdef;
    i_word_bank <= 1'b1;
    i_word_channel <= 5'h15;
    @(posedge i_clock);
    i_word_valid <= 1'b0;
    #1 chk("word valid", 32'h1, {31'h0, o_data_valid});
    chk("data word", 32'h75ab_cdef, o_data_word);
    $display("test data word done");

    wr(panel_pkg::ADDR_CONTROL, 32'h0);
    wr(panel_pkg::ADDR_IRQ_CLEAR, 32'hf);
    wr(panel_pkg::ADDR_IRQ_ENABLE, 32'h1);
    rdchk("irq enable", panel_pkg::ADDR_IRQ_ENABLE, 32'h1);
    chk("irq", 32'h0, {31'h0, o_irq});
    far.pulse(0, 1);
    chk("irq", 32'h1, {31'h0, o_irq});
    wr(panel_pkg::ADDR_IRQ_ENABLE, 32'h0);
    cyc(1);
    chk("irq", 32'h0, {31'h0, o_irq});
    wr(panel_pkg::ADDR_IRQ_ENABLE, 32'h1);
    cyc(1);
    chk("irq", 32'h1, {31'h0, o_irq});
    wr(panel_pkg::ADDR_IRQ_CLEAR, 32'h1);
    cyc(1);
    chk("irq", 32'h0, {31'h0, o_irq});
    $display("test interrupt done");
    complete_run();
  end
endmodule : test_panel_routing
